/* File: logic/phy_power_pkg.sv */
package phy_power_pkg;
  // register map, word byte addresses
  localparam logic [3:0] ctrl_addr                       = 4'h0;
  localparam logic [3:0] vendor_addr                     = 4'h4;
  localparam logic [3:0] status_addr                     = 4'h8;
  localparam logic [3:0] pulse_addr                      = 4'hC;
  localparam int         control_reg_power_down_position = 11;
  localparam int         vendor_reg_rx_save_position     = 0;
  localparam int         vendor_reg_tx_highz_position    = 12;
  localparam int         vendor_speed_position           = 13;
  // status bit positions
  localparam int         st_sig_det  = 0;
  localparam int         st_low_thr  = 1;
  localparam int         st_rx_pwr   = 2;
  localparam int         st_cdr_data = 3;
  localparam int         st_core_on  = 4;
  localparam int         st_tx_drive = 5;
  // clock synthesis ratios against the reference
  localparam int         synth_mul_100 = 5;
  localparam int         synth_div_100 = 1;
  localparam int         synth_mul_10  = 4;
  localparam int         synth_div_10  = 5;
  // timing
  localparam int         clk_period_ns    = 100;
  localparam int         loss_100_ns      = 1200;
  localparam int         loss_100_cycles  = loss_100_ns / clk_period_ns;
  localparam int         min_valid_pulses = 2;
  localparam logic [31:0] unmapped_value  = 32'h0000_0000;

  typedef struct packed {
    logic rx_save;
    logic tx_highz;
    logic speed_100;
  } vendor_cfg_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avalon_req_t;
endpackage

/* File: logic/signal_qualifier.sv */
`timescale 1ns/1ps
module signal_qualifier #(
  parameter int LOSS_CYCLES = phy_power_pkg::loss_100_cycles,
  parameter int MIN_PULSES  = phy_power_pkg::min_valid_pulses
) (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  input  wire logic active_i,
  input  wire logic speed_100_i,
  input  wire logic line_pulse_i,
  input  wire logic manchester_i,
  output logic      sig_det_o
);
  logic [7:0] pulse_cnt;
  logic [7:0] idle_cnt;

  // pulse counting and loss timing
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !active_i) begin
      sig_det_o <= 1'b0;
      pulse_cnt <= 8'h00;
      idle_cnt  <= 8'h00;
    end else if (enable_i) begin
      if (!sig_det_o) begin
        if (line_pulse_i) begin
          if (pulse_cnt + 8'h01 >= 8'(MIN_PULSES)) begin
            sig_det_o <= 1'b1;
            pulse_cnt <= 8'h00;
          end else begin
            pulse_cnt <= pulse_cnt + 8'h01;
          end
        end
        idle_cnt <= 8'h00;
      end else if (speed_100_i) begin
        if (line_pulse_i) begin
          idle_cnt <= 8'h00;
        end else if (idle_cnt + 8'h01 >= 8'(LOSS_CYCLES)) begin
          sig_det_o <= 1'b0;
          idle_cnt  <= 8'h00;
        end else begin
          idle_cnt <= idle_cnt + 8'h01;
        end
      end else if (!manchester_i) begin
        sig_det_o <= 1'b0;
      end
    end
  end

  sig_det_2p_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    $rose(sig_det_o) |-> $past(line_pulse_i))
    else $error("signal detect rose without a pulse");

  loss_10_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (enable_i && active_i && sig_det_o && !speed_100_i && !manchester_i)
    |=> !sig_det_o)
    else $error("10M detect held without data");
endmodule

/* File: logic/phy_power_ctrl.sv */
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module phy_power_ctrl #(
  parameter int LOSS_CYCLES = phy_power_pkg::loss_100_cycles
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        line_pulse_i,
  input  wire logic        manchester_i,
  input  wire logic        preamble_i,
  input  wire logic        rx_data_i,
  output logic             core_on_o,
  output logic             rx_path_on_o,
  output logic             rx_clk_en_o,
  output logic             tx_drive_oe_o,
  output logic             tx_clk_oe_o,
  output logic             tx_clk_pullup_o,
  output logic             sig_det_o,
  output logic             low_threshold_o,
  output logic             adapt_release_o,
  output logic             cdr_ref_line_o,
  output logic             cdr_realign_o,
  output logic [2:0]       synth_mul_o,
  output logic [2:0]       synth_div_o
);
  logic                        power_down;
  phy_power_pkg::vendor_cfg_t  cfg;
  phy_power_pkg::avalon_req_t  req;
  logic                        answered;
  logic                        det;
  logic [7:0]                  pulse_total;
  logic                        rx_active;

  assign req = '{address: avs_address_i, read: avs_read_i,
                 write: avs_write_i, writedata: avs_writedata_i};

  // receive path powered while the core is on, unless save mode gates it in 100M idle
  assign rx_active = core_on_o &&
    !(cfg.rx_save && cfg.speed_100 && !det);

  signal_qualifier #(
    .LOSS_CYCLES (LOSS_CYCLES),
    .MIN_PULSES  (phy_power_pkg::min_valid_pulses)
  ) u_qual (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .enable_i     (clk_en_i),
    .active_i     (core_on_o),
    .speed_100_i  (cfg.speed_100),
    .line_pulse_i (line_pulse_i),
    .manchester_i (manchester_i),
    .sig_det_o    (det)
  );

  // one wait state then answer; registers run in power-down too
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      answered          <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else if (clk_en_i) begin
      answered          <= (req.read || req.write) && avs_waitrequest_o
                           && !answered;
      avs_waitrequest_o <= !((req.read || req.write) && avs_waitrequest_o
                           && !answered);
    end
  end

  // register writes, taken on the answering edge
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      power_down <= 1'b0;
      cfg        <= '{rx_save: 1'b0, tx_highz: 1'b0, speed_100: 1'b1};
    end else if (clk_en_i && req.write && !avs_waitrequest_o) begin
      if (req.address == phy_power_pkg::ctrl_addr) begin
        power_down <= req.writedata[
          phy_power_pkg::control_reg_power_down_position];
      end
      if (req.address == phy_power_pkg::vendor_addr) begin
        cfg.rx_save   <= req.writedata[
          phy_power_pkg::vendor_reg_rx_save_position];
        cfg.tx_highz  <= req.writedata[
          phy_power_pkg::vendor_reg_tx_highz_position];
        cfg.speed_100 <= req.writedata[phy_power_pkg::vendor_speed_position];
      end
    end
  end

  // pulse counter readable for diagnostics
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pulse_total <= 8'h00;
    end else if (clk_en_i && line_pulse_i && rx_active) begin
      pulse_total <= pulse_total + 8'h01;
    end
  end

  // read data mux, registered
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= phy_power_pkg::unmapped_value;
    end else if (clk_en_i) begin
      avs_readdata_o <= phy_power_pkg::unmapped_value;
      if (req.read && avs_waitrequest_o && !answered) begin
        unique case (req.address)
          phy_power_pkg::ctrl_addr:
            avs_readdata_o[phy_power_pkg::control_reg_power_down_position]
              <= power_down;
          phy_power_pkg::vendor_addr: begin
            avs_readdata_o[phy_power_pkg::vendor_reg_rx_save_position]
              <= cfg.rx_save;
            avs_readdata_o[phy_power_pkg::vendor_reg_tx_highz_position]
              <= cfg.tx_highz;
            avs_readdata_o[phy_power_pkg::vendor_speed_position]
              <= cfg.speed_100;
          end
          phy_power_pkg::status_addr: begin
            avs_readdata_o[phy_power_pkg::st_sig_det]  <= sig_det_o;
            avs_readdata_o[phy_power_pkg::st_low_thr]  <= low_threshold_o;
            avs_readdata_o[phy_power_pkg::st_rx_pwr]   <= rx_path_on_o;
            avs_readdata_o[phy_power_pkg::st_cdr_data] <= cdr_ref_line_o;
            avs_readdata_o[phy_power_pkg::st_core_on]  <= core_on_o;
            avs_readdata_o[phy_power_pkg::st_tx_drive] <= tx_drive_oe_o;
          end
          phy_power_pkg::pulse_addr:
            avs_readdata_o[7:0] <= pulse_total;
          default:
            avs_readdata_o <= phy_power_pkg::unmapped_value;
        endcase
      end
    end
  end

  // power gating outputs
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      core_on_o       <= 1'b1;
      rx_path_on_o    <= 1'b1;
      rx_clk_en_o     <= 1'b0;
      tx_drive_oe_o   <= 1'b1;
      tx_clk_oe_o     <= 1'b1;
      tx_clk_pullup_o <= 1'b0;
    end else if (clk_en_i) begin
      core_on_o       <= !power_down;
      rx_path_on_o    <= rx_active;
      rx_clk_en_o     <= rx_active &&
        !(cfg.rx_save && cfg.speed_100 && !rx_data_i);
      tx_drive_oe_o   <= !power_down && !cfg.tx_highz;
      tx_clk_oe_o     <= !power_down && !cfg.tx_highz;
      tx_clk_pullup_o <= cfg.tx_highz;
    end
  end

  // synthesizer ratio by speed
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      synth_mul_o <= 3'(phy_power_pkg::synth_mul_100);
      synth_div_o <= 3'(phy_power_pkg::synth_div_100);
    end else if (clk_en_i) begin
      synth_mul_o <= cfg.speed_100 ? 3'(phy_power_pkg::synth_mul_100)
                                   : 3'(phy_power_pkg::synth_mul_10);
      synth_div_o <= cfg.speed_100 ? 3'(phy_power_pkg::synth_div_100)
                                   : 3'(phy_power_pkg::synth_div_10);
    end
  end

  // detect, threshold and recovery reference
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sig_det_o       <= 1'b0;
      low_threshold_o <= 1'b0;
      adapt_release_o <= 1'b0;
      cdr_ref_line_o  <= 1'b0;
      cdr_realign_o   <= 1'b0;
    end else if (clk_en_i) begin
      sig_det_o       <= det;
      low_threshold_o <= det;
      adapt_release_o <= det;
      cdr_ref_line_o  <= det && cfg.speed_100;
      cdr_realign_o   <= !cfg.speed_100 && preamble_i && core_on_o;
    end
  end

  sequence write_done_s;
    req.write && !avs_waitrequest_o;
  endsequence

  wait_bound_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && (req.read || req.write) && avs_waitrequest_o && !answered)
    |=> !avs_waitrequest_o)
    else $error("bus answer late");
  pd_gates_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && power_down) |=> !core_on_o && !tx_drive_oe_o)
    else $error("core on in power-down");
  rx_gate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && core_on_o && cfg.rx_save && cfg.speed_100 && !det)
    |=> !rx_path_on_o && !rx_clk_en_o)
    else $error("rx path on while idle");
  ten_no_gate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && core_on_o && !cfg.speed_100) |=> rx_path_on_o)
    else $error("rx gated in 10M");
  highz_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && cfg.tx_highz) |=> !tx_clk_oe_o && tx_clk_pullup_o)
    else $error("tx clock driven in high-z");
  highz_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $fell(cfg.tx_highz) |-> $past(req.write && !avs_waitrequest_o))
    else $error("high-z cleared without write");
  synth_ratio_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (clk_en_i && !cfg.speed_100)
    |=> synth_mul_o == 3'(phy_power_pkg::synth_mul_10)
    && synth_div_o == 3'(phy_power_pkg::synth_div_10))
    else $error("wrong 10M ratio");
  thr_restore_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (clk_en_i && !det) |=> !low_threshold_o)
    else $error("threshold not restored");
  cdr_ref_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clk_en_i && det && cfg.speed_100) |=> cdr_ref_line_o)
    else $error("cdr not on line reference");
endmodule

/* File: test/line_partner.sv */
`timescale 1ns/1ps
module line_partner (
  input  wire logic core_clk_i,
  output logic      line_pulse_o,
  output logic      manchester_o,
  output logic      preamble_o,
  output logic      rx_data_o
);
  // quiet line at start
  initial begin
    line_pulse_o = 1'b0;
    manchester_o = 1'b0;
    preamble_o   = 1'b0;
    rx_data_o    = 1'b0;
  end
  // single-cycle pulses, one idle cycle apart
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      line_pulse_o <= 1'b1;
      @(posedge core_clk_i);
      line_pulse_o <= 1'b0;
    end
  endtask
  // level signals of the receive side
  task automatic levels(input logic m, input logic p, input logic d);
    @(posedge core_clk_i);
    manchester_o <= m;
    preamble_o   <= p;
    rx_data_o    <= d;
  endtask
endmodule

/* File: test/tb_phy_power_and_signal_detect.sv */
`timescale 1ns/1ps
module tb_phy_power_and_signal_detect;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        clk_en     = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        lp, mc, pr, rd;
  logic        core_on, rx_on, rx_clk, tx_oe, txc_oe, txc_pu;
  logic        det, low_thr, adapt, cdr_line, realign;
  logic [2:0]  mul, div;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #50 core_clk_i = ~core_clk_i;

  line_partner p (.core_clk_i(core_clk_i), .line_pulse_o(lp),
    .manchester_o(mc), .preamble_o(pr), .rx_data_o(rd));

  phy_power_ctrl #(.LOSS_CYCLES(6)) uut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .line_pulse_i(lp), .manchester_i(mc), .preamble_i(pr),
    .rx_data_i(rd), .core_on_o(core_on), .rx_path_on_o(rx_on),
    .rx_clk_en_o(rx_clk), .tx_drive_oe_o(tx_oe), .tx_clk_oe_o(txc_oe),
    .tx_clk_pullup_o(txc_pu), .sig_det_o(det),
    .low_threshold_o(low_thr), .adapt_release_o(adapt),
    .cdr_ref_line_o(cdr_line), .cdr_realign_o(realign),
    .synth_mul_o(mul), .synth_div_o(div));

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one avalon access, held until waitrequest samples low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    rdata = avs_readdata_o;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    wait_cyc(4);
    reset_n_i <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    wait_cyc(4);
    reset_n_i <= 1'b1;
    check("tx_oe", tx_oe, 1);
    check("mul", mul, 5);
    bus(0, 4'h4, 0);
    check("vendor", rdata, 32'h0000_2000);
    bus(0, 4'h2, 0);
    check("unmapped", rdata, 0);
    $display("test reset done");
    // chip power-down, bus still answers
    bus(1, 4'h0, 32'h0000_0800);
    wait_cyc(2);
    check("core_on", core_on, 0);
    bus(0, 4'h0, 0);
    check("ctrl", rdata, 32'h0000_0800);
    bus(1, 4'h0, 0);
    wait_cyc(2);
    check("core_on", core_on, 1);
    $display("test power_down done");
    // 100M detect and loss
    p.pulses(2);
    wait_cyc(3);
    check("det", det, 1);
    check("low_thr", low_thr, 1);
    check("adapt", adapt, 1);
    check("cdr_line", cdr_line, 1);
    wait_cyc(12);
    check("det", det, 0);
    check("low_thr", low_thr, 0);
    check("cdr_line", cdr_line, 0);
    $display("test detect_100 done");
    // receive power save at 100M
    bus(1, 4'h4, 32'h0000_2001);
    wait_cyc(2);
    check("rx_on", rx_on, 0);
    check("rx_clk", rx_clk, 0);
    p.levels(0, 0, 1);
    p.pulses(2);
    wait_cyc(3);
    check("rx_on", rx_on, 1);
    check("rx_clk", rx_clk, 1);
    p.levels(0, 0, 0);
    wait_cyc(2);
    check("rx_clk", rx_clk, 0);
    check("rx_on", rx_on, 1);
    wait_cyc(12);
    $display("test rx_save done");
    // 10M: no gating, synth ratio, manchester loss, realign
    bus(1, 4'h4, 32'h0000_0001);
    wait_cyc(2);
    check("rx_on", rx_on, 1);
    check("mul", mul, 4);
    check("div", div, 5);
    p.levels(1, 0, 0);
    p.pulses(2);
    wait_cyc(3);
    check("det", det, 1);
    p.levels(0, 1, 0);
    wait_cyc(3);
    check("det", det, 0);
    check("low_thr", low_thr, 0);
    check("realign", realign, 1);
    p.levels(0, 0, 0);
    bus(0, 4'hC, 0);
    check("pulses", rdata, 32'h0000_0004);
    $display("test ten_meg done");
    // transmit high impedance, cleared here by reset (a vendor write also clears it)
    bus(1, 4'h4, 32'h0000_3000);
    wait_cyc(2);
    check("tx_oe", tx_oe, 0);
    check("txc_oe", txc_oe, 0);
    check("txc_pu", txc_pu, 1);
    check("rx_on", rx_on, 1);
    check("mul", mul, 5);
    bus(0, 4'h8, 0);
    check("status", rdata, 32'h0000_0014);
    // clock enable low freezes the qualifier
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    p.pulses(2);
    wait_cyc(3);
    check("det_frozen", det, 0);
    @(posedge core_clk_i);
    clk_en <= 1'b1;
    do_reset();
    wait_cyc(2);
    check("tx_oe", tx_oe, 1);
    check("txc_pu", txc_pu, 0);
    bus(0, 4'h4, 0);
    check("vendor", rdata, 32'h0000_2000);
    $display("test tx_highz done");
    tally_and_finish();
  end
endmodule
